// >>> rtl/usf_map.vh
`ifndef USF_MAP_VH
`define USF_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define USF_ADDR_DATA 8'h00
`define USF_ADDR_STAT 8'h04
`define USF_ADDR_CTRL 8'h08
`define USF_ADDR_IRQ_STAT 8'h0c
`define USF_ADDR_IRQ_MASK 8'h10
// ----------------------------------------
// port_status_reg bit positions
// ----------------------------------------
`define USF_ST_TXE 0
`define USF_ST_TXC 1
`define USF_ST_RXR 2
`define USF_ST_RXIDLE 3
`define USF_ST_OVR 4
`define USF_ST_FERR 5
`define USF_ST_NOISE 6
`define USF_ST_PERR 7
// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define USF_CT_PEN 0
`define USF_CT_TXEN 1
`define USF_CT_RXIE 2
// ----------------------------------------
// interrupt status / mask bit positions
// ----------------------------------------
`define USF_IRQ_RX 0
`define USF_IRQ_TXE 1
`define USF_IRQ_TXC 2
`define USF_IRQ_ERR 3
// ----------------------------------------
// reset values
// ----------------------------------------
`define USF_CTRL_RST 3'h0
`define USF_IRQ_RST 4'h0
`endif

// >>> rtl/usf_rx_flags.v
`timescale 1ns/100ps
module usf_rx_flags #(
  parameter DATA_W = 8
) (
  input wire clk_sys,
  input wire srst,
  input wire port_en,
  input wire start_det,
  input wire stop_done,
  input wire char_done,
  input wire [DATA_W-1:0] char_in,
  input wire noise_in,
  input wire frame_in,
  input wire parity_in,
  input wire rd_clear,
  input wire err_clear,
  output reg rx_idle_flag_r,
  output reg rx_data_ready_flag_r,
  output reg noise_flag_r,
  output reg framing_error_flag_r,
  output reg parity_error_flag_r,
  output reg overrun_flag_r,
  output reg [DATA_W-1:0] rx_data_r,
  output wire xfer,
  output wire ovr_set
);
  // room exists if empty or being emptied in this very cycle
  assign xfer = port_en & char_done & ~overrun_flag_r & (~rx_data_ready_flag_r | rd_clear); // [R15]
  assign ovr_set = port_en & char_done & ~overrun_flag_r & rx_data_ready_flag_r & ~rd_clear;

  always @(posedge clk_sys) begin
    if (srst || !port_en) begin
      rx_idle_flag_r <= 1'b1; // [R14]
      rx_data_ready_flag_r <= 1'b0; // [R14]
      noise_flag_r <= 1'b0;
      framing_error_flag_r <= 1'b0;
      parity_error_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      rx_data_r <= {DATA_W{1'b0}};
    end else begin
      if (start_det) begin
        rx_idle_flag_r <= 1'b0; // [R1]
      end else if (stop_done) begin
        rx_idle_flag_r <= 1'b1; // [R2]
      end
      if (xfer) begin
        rx_data_r <= char_in;
        rx_data_ready_flag_r <= 1'b1; // [R3]
      end else if (rd_clear) begin
        rx_data_ready_flag_r <= 1'b0; // [R6]
      end
      // noise, framing and parity flags land with the ready flag; set wins over clear
      noise_flag_r <= (xfer & noise_in) | (noise_flag_r & ~err_clear); // [R5]
      framing_error_flag_r <= (xfer & frame_in) | (framing_error_flag_r & ~err_clear); // [R5]
      parity_error_flag_r <= (xfer & parity_in) | (parity_error_flag_r & ~err_clear); // [R5]
      overrun_flag_r <= ovr_set | (overrun_flag_r & ~err_clear);
    end
  end
endmodule

// >>> rtl/usf_top.v
// Contract
// R1: receiver idle reads 0 from start-bit detection until that stop bit completes.
// R2: receiver idle reads 1 between stop completion and next start bit; code sets it only if rx_line_pin is high as the stop bit completes.
// R3: character moved into data register sets receive-data-ready to 1.
// R4: receive interrupt raised on that transfer only when receive irq enable is 1.
// R5: noise, framing, parity flags set in same cycle as receive-data-ready.
// R6: receive-data-ready clears after status read seeing it, data read, no more data.
// R7: transmit-complete sets when buffer empty and no data or break shifting.
// R8: transmit pin held high while transmit-complete is 1.
// R9: transmit-complete clears on status read seeing it then data write.
// R10: transmit-complete never asserted while data or break is queued; code leaves it at 1 if a break starts while it is already 1.
// R11: buffer-empty goes 1 when shifter takes the character, 0 until then.
// R12: buffer-empty clears on status read seeing it then data write.
// R13: setting transmitter enable also sets buffer-empty.
// R14: port disable clears receive and error flags, sets idle/complete/empty flags.
// R15: overrun set blocks further receive transfers until it is cleared.
// R16: flags are clocked and read-only; status writes do nothing.
`timescale 1ns/100ps
`include "usf_map.vh"
module usf_top #(
  parameter DATA_W = 8,
  parameter ADDR_W = 8
) (
  input wire clk_sys,
  input wire srst,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq_o,
  // receiver side of the port
  input wire rx_line_pin,
  input wire rx_start_det,
  input wire rx_stop_done,
  input wire rx_char_done,
  input wire [DATA_W-1:0] rx_char,
  input wire rx_noise_det,
  input wire rx_frame_err_det,
  input wire rx_parity_err_det,
  // transmitter side of the port
  input wire tx_shift_load,
  input wire tx_shift_busy,
  input wire tx_break_active,
  input wire tx_serial_bit,
  output reg [DATA_W-1:0] tx_data_r,
  output reg tx_data_valid_r,
  output reg tx_line_pin,
  output reg port_enable_r,
  output reg transmitter_enable_r
);
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // low two address bits ignored: registers sit on word boundaries
  function hit;
    input [ADDR_W-1:0] a;
    input [7:0] off;
    begin
      hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    end
  endfunction

  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire acc_rd = acc & ~wb_we_i;
  wire acc_wr = acc & wb_we_i & wb_sel_i[0];

  wire sel_data = hit(wb_adr_i, `USF_ADDR_DATA);
  wire sel_stat = hit(wb_adr_i, `USF_ADDR_STAT);
  wire sel_ctrl = hit(wb_adr_i, `USF_ADDR_CTRL);
  wire sel_istat = hit(wb_adr_i, `USF_ADDR_IRQ_STAT);
  wire sel_imask = hit(wb_adr_i, `USF_ADDR_IRQ_MASK);

  wire data_rd = acc_rd & sel_data;
  wire data_wr = acc_wr & sel_data;
  wire stat_rd = acc_rd & sel_stat;
  wire data_acc = data_rd | data_wr;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg rx_irq_enable_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_stat_nxt;
  reg [3:0] irq_mask_r;
  reg txen_d_r;

  wire wr_ctrl = acc_wr & sel_ctrl;
  wire pen_nxt = wr_ctrl ? wb_dat_i[`USF_CT_PEN] : port_enable_r;

  always @(posedge clk_sys) begin
    if (srst) begin
      {rx_irq_enable_r, transmitter_enable_r, port_enable_r} <= `USF_CTRL_RST;
      txen_d_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        port_enable_r <= wb_dat_i[`USF_CT_PEN];
        rx_irq_enable_r <= wb_dat_i[`USF_CT_RXIE];
      end
      // disabling the port also drops the transmitter enable
      if (!pen_nxt) begin
        transmitter_enable_r <= 1'b0; // [R14]
      end else if (wr_ctrl) begin
        transmitter_enable_r <= wb_dat_i[`USF_CT_TXEN];
      end
      txen_d_r <= transmitter_enable_r;
    end
  end

  // re-enabling the transmitter sets buffer-empty even while a char is still pending in the holding register
  wire txen_rise = transmitter_enable_r & ~txen_d_r; // [R13]

  // ----------------------------------------
  // flag units
  // ----------------------------------------
  wire rx_idle_flag;
  wire rx_data_ready_flag;
  wire noise_flag;
  wire framing_error_flag;
  wire parity_error_flag;
  wire overrun_flag;
  wire [DATA_W-1:0] rx_data;
  wire rx_xfer;
  wire rx_ovr_set;
  wire tx_buffer_empty_flag;
  wire tx_complete_flag;
  wire tx_pending;
  wire txe_set;
  wire txc_set;

  // clear sequence arming: status read that saw the flag set
  reg arm_rx_r;
  reg arm_err_r;
  reg arm_txe_r;
  reg arm_txc_r;

  wire rd_clear = data_rd & arm_rx_r; // [R6]
  wire err_clear = data_acc & arm_err_r;
  wire clr_txe = data_wr & arm_txe_r; // [R12]
  wire clr_txc = data_wr & arm_txc_r; // [R9]

  usf_rx_flags #(
    .DATA_W(DATA_W)
  ) u_rx (
    .clk_sys(clk_sys),
    .srst(srst),
    .port_en(port_enable_r),
    .start_det(rx_start_det),
    .stop_done(rx_stop_done & rx_line_pin),
    .char_done(rx_char_done),
    .char_in(rx_char),
    .noise_in(rx_noise_det),
    .frame_in(rx_frame_err_det),
    .parity_in(rx_parity_err_det),
    .rd_clear(rd_clear),
    .err_clear(err_clear),
    .rx_idle_flag_r(rx_idle_flag),
    .rx_data_ready_flag_r(rx_data_ready_flag),
    .noise_flag_r(noise_flag),
    .framing_error_flag_r(framing_error_flag),
    .parity_error_flag_r(parity_error_flag),
    .overrun_flag_r(overrun_flag),
    .rx_data_r(rx_data),
    .xfer(rx_xfer),
    .ovr_set(rx_ovr_set)
  );

  usf_tx_flags u_tx (
    .clk_sys(clk_sys),
    .srst(srst),
    .port_en(port_enable_r),
    .txen_rise(txen_rise),
    .data_wr(data_wr & port_enable_r),
    .clr_txe(clr_txe),
    .clr_txc(clr_txc),
    .shift_load(tx_shift_load),
    .shift_busy(tx_shift_busy),
    .break_active(tx_break_active),
    .tx_buffer_empty_flag_r(tx_buffer_empty_flag),
    .tx_complete_flag_r(tx_complete_flag),
    .tx_pending_r(tx_pending),
    .txe_set(txe_set),
    .txc_set(txc_set)
  );

  // ----------------------------------------
  // status register image
  // ----------------------------------------
  wire [7:0] port_status_reg;
  assign port_status_reg[`USF_ST_TXE] = tx_buffer_empty_flag;
  assign port_status_reg[`USF_ST_TXC] = tx_complete_flag;
  assign port_status_reg[`USF_ST_RXR] = rx_data_ready_flag;
  assign port_status_reg[`USF_ST_RXIDLE] = rx_idle_flag;
  assign port_status_reg[`USF_ST_OVR] = overrun_flag;
  assign port_status_reg[`USF_ST_FERR] = framing_error_flag;
  assign port_status_reg[`USF_ST_NOISE] = noise_flag;
  assign port_status_reg[`USF_ST_PERR] = parity_error_flag;

  wire any_err = noise_flag | framing_error_flag | parity_error_flag | overrun_flag;

  // ----------------------------------------
  // clear sequence tracking
  // ----------------------------------------
  // a status read that saw a flag at 0 disarms it, so a stale read cannot clear it
  always @(posedge clk_sys) begin
    if (srst || !port_enable_r) begin
      arm_rx_r <= 1'b0;
      arm_err_r <= 1'b0;
      arm_txe_r <= 1'b0;
      arm_txc_r <= 1'b0;
    end else if (stat_rd) begin
      arm_rx_r <= rx_data_ready_flag;
      arm_err_r <= any_err;
      arm_txe_r <= tx_buffer_empty_flag;
      arm_txc_r <= tx_complete_flag;
    end else begin
      // a data access consumes the armed sequence
      if (data_rd) begin
        arm_rx_r <= 1'b0;
      end
      if (data_acc) begin
        arm_err_r <= 1'b0;
      end
      if (data_wr) begin
        arm_txe_r <= 1'b0;
        arm_txc_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------
  wire [3:0] irq_evt;
  assign irq_evt[`USF_IRQ_RX] = rx_xfer & rx_irq_enable_r; // [R4]
  assign irq_evt[`USF_IRQ_TXE] = txe_set & ~tx_buffer_empty_flag;
  assign irq_evt[`USF_IRQ_TXC] = txc_set & ~tx_complete_flag;
  assign irq_evt[`USF_IRQ_ERR] = rx_ovr_set | (rx_xfer & (rx_noise_det | rx_frame_err_det | rx_parity_err_det));

  wire istat_w1c = acc_wr & sel_istat;

  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (istat_w1c) begin
      irq_stat_nxt = irq_stat_nxt & ~wb_dat_i[3:0];
    end
    // an event in the clearing cycle survives
    irq_stat_nxt = irq_stat_nxt | irq_evt;
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      irq_stat_r <= `USF_IRQ_RST;
      irq_mask_r <= `USF_IRQ_RST;
      irq_o <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (acc_wr && sel_imask) begin
        irq_mask_r <= wb_dat_i[3:0];
      end
      // registered so the pin has no decode glitch; one cycle behind the status
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------
  // bus answer and read data
  // ----------------------------------------
  reg [31:0] rd_mux;

  // status writes fall through: flags are read-only
  always @* begin
    rd_mux = 32'h0000_0000;
    if (sel_data) begin
      rd_mux[DATA_W-1:0] = rx_data;
    end else if (sel_stat) begin
      rd_mux[7:0] = port_status_reg; // [R16]
    end else if (sel_ctrl) begin
      rd_mux[`USF_CT_PEN] = port_enable_r;
      rd_mux[`USF_CT_TXEN] = transmitter_enable_r;
      rd_mux[`USF_CT_RXIE] = rx_irq_enable_r;
    end else if (sel_istat) begin
      rd_mux[3:0] = irq_stat_r;
    end else if (sel_imask) begin
      rd_mux[3:0] = irq_mask_r;
    end
  end

  // answer one cycle after the take; ack high in between blocks a second take
  always @(posedge clk_sys) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else begin
      // unmapped addresses still ack, reading zero
      wb_ack_o <= acc;
    end
  end

  // read data holds until the next read so a late sample still sees it
  always @(posedge clk_sys) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (acc_rd) begin
      wb_dat_o <= rd_mux;
    end
  end

  // ----------------------------------------
  // transmit data register and line
  // ----------------------------------------
  wire tx_take = data_wr & port_enable_r;
  wire tx_valid_nxt = port_enable_r & (tx_take | (tx_pending & ~tx_shift_load));
  wire tx_line_nxt = tx_complete_flag | tx_serial_bit;

  // written data is dropped while the port is off
  always @(posedge clk_sys) begin
    if (srst) begin
      tx_data_r <= {DATA_W{1'b0}};
    end else if (tx_take) begin
      tx_data_r <= wb_dat_i[DATA_W-1:0];
    end
  end

  // mirrors the queue state seen by the shifter
  always @(posedge clk_sys) begin
    if (srst) begin
      tx_data_valid_r <= 1'b0;
    end else begin
      tx_data_valid_r <= tx_valid_nxt; // [R11]
    end
  end

  // serial bits reach the pin whenever the complete flag is 0, during a break as well as a character;
  // the complete flag overrides the shifter so the idle line stays high
  always @(posedge clk_sys) begin
    if (srst) begin
      tx_line_pin <= 1'b1;
    end else begin
      tx_line_pin <= tx_line_nxt; // [R8]
    end
  end
endmodule

// >>> rtl/usf_tx_flags.v
`timescale 1ns/100ps
module usf_tx_flags (
  input wire clk_sys,
  input wire srst,
  input wire port_en,
  input wire txen_rise,
  input wire data_wr,
  input wire clr_txe,
  input wire clr_txc,
  input wire shift_load,
  input wire shift_busy,
  input wire break_active,
  output reg tx_buffer_empty_flag_r,
  output reg tx_complete_flag_r,
  output reg tx_pending_r,
  output wire txe_set,
  output wire txc_set
);
  assign txe_set = shift_load | txen_rise;
  // nothing queued, nothing shifting, no break
  assign txc_set = tx_buffer_empty_flag_r & ~tx_pending_r & ~data_wr & ~shift_busy & ~break_active; // [R7] [R10]

  always @(posedge clk_sys) begin
    if (srst || !port_en) begin
      tx_buffer_empty_flag_r <= 1'b1; // [R14]
      tx_complete_flag_r <= 1'b1; // [R14]
      tx_pending_r <= 1'b0;
    end else begin
      if (data_wr) begin
        tx_pending_r <= 1'b1;
      end else if (shift_load) begin
        tx_pending_r <= 1'b0; // [R11]
      end
      if (txe_set) begin
        tx_buffer_empty_flag_r <= 1'b1; // [R11] [R13]
      end else if (clr_txe) begin
        tx_buffer_empty_flag_r <= 1'b0; // [R12]
      end
      if (txc_set) begin
        tx_complete_flag_r <= 1'b1; // [R7]
      end else if (clr_txc || tx_pending_r || data_wr) begin
        // a char entering the queue drops the flag at once, not a cycle late
        tx_complete_flag_r <= 1'b0; // [R9] [R10]
      end
    end
  end
endmodule

// >>> testbench/usf_chk_monitor.sv
`timescale 1ns/100ps
`include "usf_map.vh"
module usf_chk_monitor #(
  parameter DATA_W = 8,
  parameter ADDR_W = 8
) (
  input wire clk_sys,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire irq_o,
  input wire tx_shift_load,
  input wire tx_serial_bit,
  input wire [DATA_W-1:0] tx_data_r,
  input wire tx_data_valid_r,
  input wire tx_line_pin,
  input wire port_enable_r,
  input wire transmitter_enable_r
);
  wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = tk & wb_we_i & wb_sel_i[0];
  wire d0 = wb_dat_i[0];
  wire [7:0] d8 = wb_dat_i[7:0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_ack; tk |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack one cycle after request");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_unmap; tk && !wb_we_i && wb_adr_i == 8'h14 |=> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_pen; wr && wb_adr_i == `USF_ADDR_CTRL |=> port_enable_r == $past(d0); endproperty
  a_pen: assert property (p_pen) else $error("port enable not taken");
  property p_q;
    wr && wb_adr_i == `USF_ADDR_DATA && port_enable_r && transmitter_enable_r
    |=> tx_data_valid_r && tx_data_r == $past(d8);
  endproperty
  a_q: assert property (p_q) else $error("written char not queued");
  property p_load; tx_shift_load && !wr |=> !tx_data_valid_r; endproperty
  a_load: assert property (p_load) else $error("char still queued after load");
  property p_line; tx_data_valid_r && port_enable_r |=> tx_line_pin == $past(tx_serial_bit); endproperty
  a_line: assert property (p_line) else $error("line forced idle while queued");
  property p_idle; !port_enable_r [*3] |-> tx_line_pin; endproperty
  a_idle: assert property (p_idle) else $error("line not idle while disabled");
  property p_mask; wr && wb_adr_i == `USF_ADDR_IRQ_MASK && wb_dat_i[3:0] == 4'h0 |=> ##1 !irq_o; endproperty
  a_mask: assert property (p_mask) else $error("irq high with mask clear");
endmodule
bind usf_top usf_chk_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (.clk_sys, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .tx_shift_load,
  .tx_serial_bit, .tx_data_r, .tx_data_valid_r, .tx_line_pin, .port_enable_r, .transmitter_enable_r);

// >>> testbench/usf_peer.sv
`timescale 1ns/100ps
module usf_peer (
  input wire clk_sys,
  input wire srst,
  input wire [7:0] tx_data_r,
  input wire tx_data_valid_r,
  output reg rx_line_pin = 1'b1,
  output reg rx_start_det = 1'b0,
  output reg rx_stop_done = 1'b0,
  output reg rx_char_done = 1'b0,
  output reg [7:0] rx_char = 8'h00,
  output reg rx_noise_det = 1'b0,
  output reg rx_frame_err_det = 1'b0,
  output reg rx_parity_err_det = 1'b0,
  output reg tx_shift_load = 1'b0,
  output reg tx_shift_busy = 1'b0,
  output reg tx_break_active = 1'b0,
  output reg tx_serial_bit = 1'b1
);
  reg [9:0] sh = 10'h3ff;
  reg [3:0] cnt = 4'h0;
  reg [2:0] wt = 3'h0;
  // slow shifter: lets software see the queued state before the load
  always @(posedge clk_sys) begin
    tx_shift_load <= 1'b0;
    if (srst) begin
      cnt <= 4'h0;
      wt <= 3'h0;
      tx_shift_busy <= 1'b0;
      tx_serial_bit <= 1'b1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      tx_serial_bit <= sh[0];
      sh <= {1'b1, sh[9:1]};
      if (cnt == 4'h1) begin
        tx_shift_busy <= 1'b0;
        tx_serial_bit <= 1'b1;
      end
    end else if (tx_data_valid_r) begin
      wt <= wt + 3'h1;
      if (wt == 3'h7) begin
        tx_shift_load <= 1'b1;
        sh <= {1'b1, tx_data_r, 1'b0};
        cnt <= 4'ha;
        tx_shift_busy <= 1'b1;
      end
    end
  end
  task start_bit;
    @(posedge clk_sys);
    rx_line_pin <= 1'b0;
    rx_start_det <= 1'b1;
    @(posedge clk_sys);
    rx_start_det <= 1'b0;
  endtask
  task set_break(input b);
    @(posedge clk_sys);
    tx_break_active <= b;
  endtask
  // stale char and error levels are inverted so nothing relies on them
  task char_end(input [7:0] c, input [2:0] e);
    @(posedge clk_sys);
    rx_char <= c;
    {rx_parity_err_det, rx_frame_err_det, rx_noise_det} <= e;
    rx_char_done <= 1'b1;
    @(posedge clk_sys);
    rx_char_done <= 1'b0;
    rx_char <= ~c;
    {rx_parity_err_det, rx_frame_err_det, rx_noise_det} <= ~e;
    rx_line_pin <= 1'b1;
    rx_stop_done <= 1'b1;
    @(posedge clk_sys);
    rx_stop_done <= 1'b0;
  endtask
endmodule

// >>> testbench/usf_top_tb.sv
`timescale 1ns/100ps
`include "usf_map.vh"
module usf_top_tb;
  reg clk_sys = 1'b0;
  reg srst = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hf;
  reg [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_o, rx_line_pin, rx_start_det, rx_stop_done, rx_char_done;
  wire rx_noise_det, rx_frame_err_det, rx_parity_err_det, tx_shift_load, tx_shift_busy;
  wire tx_break_active, tx_serial_bit, tx_data_valid_r, tx_line_pin, port_enable_r, transmitter_enable_r;
  wire [7:0] rx_char, tx_data_r;
  reg [31:0] rd = 32'h0;
  int err_total = 0;
  int checked = 0;
  int n;
  usf_top u_dut (.clk_sys, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq_o, .rx_line_pin, .rx_start_det, .rx_stop_done, .rx_char_done, .rx_char,
    .rx_noise_det, .rx_frame_err_det, .rx_parity_err_det, .tx_shift_load, .tx_shift_busy,
    .tx_break_active, .tx_serial_bit, .tx_data_r, .tx_data_valid_r, .tx_line_pin, .port_enable_r,
    .transmitter_enable_r);
  usf_peer u_peer (.clk_sys, .srst, .tx_data_r, .tx_data_valid_r, .rx_line_pin, .rx_start_det,
    .rx_stop_done, .rx_char_done, .rx_char, .rx_noise_det, .rx_frame_err_det, .rx_parity_err_det,
    .tx_shift_load, .tx_shift_busy, .tx_break_active, .tx_serial_bit);
  initial forever #2 clk_sys = ~clk_sys;
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wb_go(input [7:0] a, input w, input [31:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task st(input [7:0] e);
    wb_go(`USF_ADDR_STAT, 1'b0, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    wrap_up;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    st(8'h0b);
    wb_go(`USF_ADDR_STAT, 1'b1, 32'hff);
    st(8'h0b);
    wb_go(`USF_ADDR_CTRL, 1'b1, 32'h7);
    st(8'h0b);
    wb_go(`USF_ADDR_IRQ_MASK, 1'b1, 32'h1);
    u_peer.start_bit;
    st(8'h03);
    u_peer.char_end(8'ha5, 3'b011);
    st(8'h6f);
    chk({31'h0, irq_o}, 32'h1);
    wb_go(`USF_ADDR_IRQ_STAT, 1'b1, 32'hf);
    wb_go(`USF_ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    // second and third chars arrive while the first is unread
    u_peer.start_bit;
    u_peer.char_end(8'h3c, 3'b000);
    u_peer.start_bit;
    u_peer.char_end(8'h77, 3'b000);
    st(8'h7f);
    wb_go(`USF_ADDR_DATA, 1'b0, 32'h0);
    chk(rd & 32'hff, 32'ha5);
    st(8'h0b);
    wb_go(`USF_ADDR_CTRL, 1'b1, 32'h3);
    wb_go(`USF_ADDR_IRQ_STAT, 1'b1, 32'hf);
    u_peer.start_bit;
    u_peer.char_end(8'h11, 3'b000);
    wb_go(`USF_ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(rd & 32'h1, 32'h0);
    // data read without an arming status read keeps the flag
    wb_go(`USF_ADDR_DATA, 1'b0, 32'h0);
    chk(rd & 32'hff, 32'h11);
    st(8'h0f);
    wb_go(`USF_ADDR_DATA, 1'b0, 32'h0);
    st(8'h0b);
    wb_go(`USF_ADDR_DATA, 1'b1, 32'h5a);
    st(8'h08);
    chk({24'h0, tx_data_r}, 32'h5a);
    n = 0;
    while (tx_data_valid_r !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 40) err_total++;
    st(8'h09);
    repeat (16) @(posedge clk_sys);
    st(8'h0b);
    chk({31'h0, tx_line_pin}, 32'h1);
    // break holds off completion; re-enabling the transmitter sets the buffer-empty flag before the load
    u_peer.set_break(1'b1);
    wb_go(`USF_ADDR_CTRL, 1'b1, 32'h1);
    wb_go(`USF_ADDR_DATA, 1'b1, 32'hc3);
    wb_go(`USF_ADDR_CTRL, 1'b1, 32'h3);
    st(8'h09);
    repeat (30) @(posedge clk_sys);
    st(8'h09);
    u_peer.set_break(1'b0);
    st(8'h0b);
    u_peer.start_bit;
    u_peer.char_end(8'h22, 3'b100);
    wb_go(`USF_ADDR_CTRL, 1'b1, 32'h2);
    st(8'h0b);
    wb_go(`USF_ADDR_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, transmitter_enable_r}, 32'h0);
    wb_go(8'h14, 1'b0, 32'h0);
    chk(rd, 32'h0);
    wb_go(`USF_ADDR_IRQ_MASK, 1'b1, 32'h0);
    repeat (3) @(posedge clk_sys);
    wrap_up;
  end
endmodule
